// ===== verilog/essd_consts.svh
// Constants for the expansion slot select decoder: addresses, fields, reset values.
// Assumes a 16-bit processor address and an 8-bit data bus.
`ifndef ESSD_CONSTS_SVH
`define ESSD_CONSTS_SVH
`define ESSD_SLOT_REG_ADDR 16'hC02D
`define ESSD_SLOT_REG_RST 8'h00
`define ESSD_SLOT_REG_WMASK 8'hF6
`define ESSD_IO_BASE 16'hC080
`define ESSD_IO_HI 8'hC0
`define ESSD_IO_NIB_LO 4'h9
`define ESSD_ROM_HI_NIB 4'hC
`define ESSD_EXP_LO 16'hC800
`define ESSD_EXP_HI 16'hCFFF
`define ESSD_SLOT_CNT 7
`define ESSD_AUX_SLOT 3
`define ESSD_IO_ALWAYS_MASK 7'h0C
`endif

// ===== verilog/essd_pkg.sv
// Types for the expansion slot select decoder.
// Assumes essd_consts.svh is on the include path.
package essd_pkg;
  typedef logic [6:0] essd_slot_vec_t;
  typedef enum logic [1:0] {
    ESSD_IDLE = 2'b00,
    ESSD_ACCESS = 2'b01
  } essd_state_t;
endpackage

// ===== verilog/essd_slot_reg.sv
// Slot-source register storage with a registered read port.
// Assumes the decoder qualifies the write enable by address.
`timescale 1ns/1ns
`include "essd_consts.svh"
module essd_slot_reg
  import essd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_we,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_q,
  output logic [7:0] o_rdata
);
  logic [7:0] q_r;
  logic [7:0] q_nxt;
  logic [7:0] rd_r;
  logic [7:0] rd_nxt;

  always_comb begin
    q_nxt = q_r;
    // Bits 3 and 0 have no function, so they never store
    if (i_we) begin
      q_nxt = i_wdata & `ESSD_SLOT_REG_WMASK;
    end
    rd_nxt = q_nxt;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      q_r <= `ESSD_SLOT_REG_RST;
      rd_r <= `ESSD_SLOT_REG_RST;
    end else begin
      q_r <= q_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign o_q = q_r;
  assign o_rdata = rd_r;
endmodule // essd_slot_reg

// ===== verilog/essd_decode.sv
// How it works
// - Slot 2 bit routes card ROM and I/O
// - Slot 1 bit routes card ROM and I/O
// - Slot 3 and 4 I/O always routed
// - Sixteen I/O locations per slot from C090
// - I/O window access drives its select low
// - Each slot gets ROM page Cn00
// - ROM page access drives its select low, except slot 3
// - C800-CFFF drives shared expansion strobe low
// - No strobe on slot 3 with aux card
// - Slot-source register lives at C02D
// - Bits 7..5 route slots 7..5; bit 4 routes slot 4 ROM only
// - Bit 3 unused, reads zero
//
// Top-level slot decoder: processor bus in, per-slot active-low selects out.
// Assumes one processor access per i_clk cycle, marked by i_bus_valid.
`timescale 1ns/1ns
`include "essd_consts.svh"
module essd_decode
  import essd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_bus_valid,
  input wire logic i_bus_write,
  input wire logic [15:0] i_bus_addr,
  input wire logic [7:0] i_bus_wdata,
  input wire logic i_aux_80col,
  output logic [7:0] o_bus_rdata,
  output logic o_bus_rvalid,
  output logic [6:0] o_io_sel_n,
  output logic [6:0] o_rom_sel_n,
  output logic o_exp_strobe_n,
  output logic o_exp_strobe_slot3_n
);
  essd_state_t state_r;
  essd_state_t state_nxt;
  logic [6:0] io_sel_n_r;
  logic [6:0] io_sel_n_nxt;
  logic [6:0] rom_sel_n_r;
  logic [6:0] rom_sel_n_nxt;
  logic exp_n_r;
  logic exp_n_nxt;
  logic exp3_n_r;
  logic exp3_n_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic reg_hit;
  logic [7:0] slot_src;
  logic [7:0] reg_rdata;
  essd_slot_vec_t io_hit;
  essd_slot_vec_t rom_hit;
  essd_slot_vec_t card_io_en;
  essd_slot_vec_t card_rom_en;
  logic exp_hit;

  // One-hot slot for a nibble 1..7, zero otherwise
  function automatic essd_slot_vec_t slot_onehot(input logic [3:0] nib);
    essd_slot_vec_t v;
    v = '0;
    unique case (nib)
      4'h1: v = 7'h01;
      4'h2: v = 7'h02;
      4'h3: v = 7'h04;
      4'h4: v = 7'h08;
      4'h5: v = 7'h10;
      4'h6: v = 7'h20;
      4'h7: v = 7'h40;
      default: v = 7'h00;
    endcase
    return v;
  endfunction

  assign reg_hit = i_bus_valid && (i_bus_addr == `ESSD_SLOT_REG_ADDR);

  essd_slot_reg u_slot_reg (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_we(reg_hit && i_bus_write),
    .i_wdata(i_bus_wdata),
    .o_q(slot_src),
    .o_rdata(reg_rdata)
  );

  always_comb begin
    // Bit n routes the ROM page of slot n to the connector
    card_rom_en[0] = slot_src[1];
    card_rom_en[1] = slot_src[2];
    // Slot 3 page always belongs to the built-in 80-column firmware
    card_rom_en[2] = 1'b0;
    card_rom_en[3] = slot_src[4];
    card_rom_en[4] = slot_src[5];
    card_rom_en[5] = slot_src[6];
    card_rom_en[6] = slot_src[7];
    // Slot 4 bit only moves ROM; its I/O and that of slot 3 are forced on below
    card_io_en[0] = slot_src[1];
    card_io_en[1] = slot_src[2];
    card_io_en[2] = 1'b0;
    card_io_en[3] = 1'b0;
    card_io_en[4] = slot_src[5];
    card_io_en[5] = slot_src[6];
    card_io_en[6] = slot_src[7];
    card_io_en = card_io_en | `ESSD_IO_ALWAYS_MASK;
    io_hit = '0;
    rom_hit = '0;
    exp_hit = 1'b0;
    if (i_bus_valid) begin
      if (i_bus_addr[15:8] == `ESSD_IO_HI && i_bus_addr[7:4] >= `ESSD_IO_NIB_LO) begin
        io_hit = slot_onehot(i_bus_addr[7:4] - 4'h8);
      end
      if (i_bus_addr[15:12] == `ESSD_ROM_HI_NIB) begin
        rom_hit = slot_onehot(i_bus_addr[11:8]);
      end
      exp_hit = (i_bus_addr >= `ESSD_EXP_LO) && (i_bus_addr <= `ESSD_EXP_HI);
    end
  end

  // Bus-cycle tracker: whether the last cycle carried a processor access
  always_comb begin
    state_nxt = ESSD_IDLE;
    unique case (state_r)
      ESSD_IDLE: begin
        if (i_bus_valid) begin
          state_nxt = ESSD_ACCESS;
        end
      end
      ESSD_ACCESS: begin
        if (i_bus_valid) begin
          state_nxt = ESSD_ACCESS;
        end
      end
      default: begin
        state_nxt = ESSD_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_r <= ESSD_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Selects are registered, so they show in the cycle after the address
  // and drop one cycle after the access ends
  always_comb begin
    io_sel_n_nxt = ~(io_hit & card_io_en);
    rom_sel_n_nxt = ~(rom_hit & card_rom_en);
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      io_sel_n_r <= 7'h7F;
      rom_sel_n_r <= 7'h7F;
    end else begin
      io_sel_n_r <= io_sel_n_nxt;
      rom_sel_n_r <= rom_sel_n_nxt;
    end
  end

  // Slot 3 gets its own strobe pin so an aux text card can mask it
  always_comb begin
    exp_n_nxt = ~exp_hit;
    exp3_n_nxt = ~(exp_hit && !i_aux_80col);
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      exp_n_r <= 1'b1;
      exp3_n_r <= 1'b1;
    end else begin
      exp_n_r <= exp_n_nxt;
      exp3_n_r <= exp3_n_nxt;
    end
  end

  // Read valid marks the cycle in which the register byte is offered
  always_comb begin
    rvalid_nxt = reg_hit && !i_bus_write;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= rvalid_nxt;
    end
  end

  assign o_io_sel_n = io_sel_n_r;
  assign o_rom_sel_n = rom_sel_n_r;
  assign o_exp_strobe_n = exp_n_r;
  assign o_exp_strobe_slot3_n = exp3_n_r;
  assign o_bus_rvalid = rvalid_r;
  assign o_bus_rdata = reg_rdata;
endmodule // essd_decode

// ===== tb/essd_decode_properties.sv
// Port checker for the slot decoder.
// Assumes o_bus_rdata always mirrors the slot-source register.
`timescale 1ns/1ns
`include "essd_consts.svh"
module essd_chk (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_bus_valid,
  input wire logic i_bus_write,
  input wire logic [15:0] i_bus_addr,
  input wire logic [7:0] i_bus_wdata,
  input wire logic i_aux_80col,
  input wire logic [7:0] o_bus_rdata,
  input wire logic o_bus_rvalid,
  input wire logic [6:0] o_io_sel_n,
  input wire logic [6:0] o_rom_sel_n,
  input wire logic o_exp_strobe_n,
  input wire logic o_exp_strobe_slot3_n
);
  logic [6:0] eio;
  logic [6:0] erom;
  logic ex;
  logic [15:0] a;
  assign a = i_bus_addr;
  assign ex = i_bus_valid && a[15:11] == 5'h19;
  always_comb begin
    eio = 7'h00;
    erom = 7'h00;
    if (i_bus_valid && a[15:8] == 8'hC0 && a[7:4] >= 4'h9) begin
      eio = (7'h01 << (a[7:4] - 4'h9)) & (o_bus_rdata[7:1] | `ESSD_IO_ALWAYS_MASK);
    end
    if (i_bus_valid && a[15:11] == 5'h18 && a[10:8] != 3'h0) begin
      // Slot 3 page always stays with the built-in firmware
      erom = (7'h01 << (a[10:8] - 3'h1)) & o_bus_rdata[7:1] & 7'h7B;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_wr;
    i_bus_valid && i_bus_write && a == `ESSD_SLOT_REG_ADDR;
  endsequence
  property p_io; 1 |=> o_io_sel_n == ~$past(eio); endproperty
  a_io: assert property (p_io) else $error("io select wrong");
  property p_rom; 1 |=> o_rom_sel_n == ~$past(erom); endproperty
  a_rom: assert property (p_rom) else $error("rom select wrong");
  property p_exp; 1 |=> o_exp_strobe_n == !$past(ex); endproperty
  a_exp: assert property (p_exp) else $error("strobe wrong");
  property p_s3; 1 |=> o_exp_strobe_slot3_n == !$past(ex && !i_aux_80col); endproperty
  a_s3: assert property (p_s3) else $error("slot 3 strobe wrong");
  property p_rv;
    1 |=> o_bus_rvalid == $past(i_bus_valid && !i_bus_write && a == `ESSD_SLOT_REG_ADDR);
  endproperty
  a_rv: assert property (p_rv) else $error("read valid wrong");
  property p_wr; s_wr |=> o_bus_rdata == ($past(i_bus_wdata) & 8'hF6); endproperty
  a_wr: assert property (p_wr) else $error("write data wrong");
  property p_hold;
    !(i_bus_valid && i_bus_write && a == `ESSD_SLOT_REG_ADDR) |=> $stable(o_bus_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("register changed");
  property p_idle; !i_bus_valid |=> &o_io_sel_n && &o_rom_sel_n && o_exp_strobe_n; endproperty
  a_idle: assert property (p_idle) else $error("select left low");
endmodule // essd_chk
bind essd_decode essd_chk u_chk (.*);

// ===== tb/essd_card.sv
// Card model: expansion ROM enable flip-flop with disable decode.
// Assumes selects arrive one clock after the address.
`timescale 1ns/1ns
module essd_card (
  input wire logic i_clk,
  input wire logic i_valid,
  input wire logic [15:0] i_addr,
  input wire logic i_rom_sel_n,
  input wire logic i_io_sel_n,
  input wire logic i_strobe_n,
  output logic o_drive,
  output logic [3:0] o_io_loc,
  output logic [7:0] o_rom_loc
);
  logic en_r = 1'b0;
  logic [15:0] addr_q = 16'h0000;
  always @(posedge i_clk) begin
    // Selects trail the address by one clock, so keep the address that raised them
    addr_q <= i_addr;
    if (!i_rom_sel_n) en_r <= 1'b1;
    // Cheap CFxx decode gives up the top page of expansion ROM
    if (i_valid && i_addr[15:8] == 8'hCF) en_r <= 1'b0;
  end
  assign o_drive = en_r && !i_strobe_n;
  assign o_io_loc = i_io_sel_n ? 4'h0 : addr_q[3:0];
  assign o_rom_loc = i_rom_sel_n ? 8'h00 : addr_q[7:0];
endmodule // essd_card

// ===== tb/tb_top.sv
// Self-checking bench for the slot decoder, one card model in slot 2.
// Assumes the checker binds itself from its own file.
`timescale 1ns/1ns
`include "essd_consts.svh"
module tb_top;
  logic clk = 1'b0, rst = 1'b1, v = 1'b0, w = 1'b0, aux = 1'b0, rv, es, e3, drv;
  logic [15:0] a = 16'h0000;
  logic [7:0] d = 8'h00, rd;
  logic [7:0] regv [2] = '{8'h28, 8'hFE};
  logic [6:0] io, rom;
  logic [3:0] iloc;
  logic [7:0] rloc;
  int err_count = 0, check_count = 0, cyc = 0;
  essd_decode dut (.i_clk(clk), .i_sys_rst(rst), .i_bus_valid(v), .i_bus_write(w),
    .i_bus_addr(a), .i_bus_wdata(d), .i_aux_80col(aux), .o_bus_rdata(rd), .o_bus_rvalid(rv),
    .o_io_sel_n(io), .o_rom_sel_n(rom), .o_exp_strobe_n(es), .o_exp_strobe_slot3_n(e3));
  essd_card card (.i_clk(clk), .i_valid(v), .i_addr(a), .i_rom_sel_n(rom[1]),
    .i_io_sel_n(io[1]), .i_strobe_n(es), .o_drive(drv), .o_io_loc(iloc), .o_rom_loc(rloc));
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 500) begin
      err_count++;
      give_verdict();
    end
  end
  task chk(input string n, input logic [7:0] s, e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task acc(input logic [15:0] ad, input logic wr);
    v = 1'b1;
    a = ad;
    w = wr;
    @(posedge clk);
    #1;
  endtask
  task give_verdict();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    @(posedge clk);
    #1;
    chk("reg", rd, 8'h00);
    foreach (regv[i]) begin
      d = regv[i];
      acc(16'hC02D, 1'b1);
      acc(16'hC02D, 1'b0);
      chk("reg", {rv, rd[6:0]}, {1'b1, regv[i][6:4], 1'b0, regv[i][2:1], 1'b0});
      for (int n = 1; n < 8; n++) begin
        acc(16'hC080 + 16'(n * 17), 1'b0);
        chk("io", {1'b0, io}, {1'b0, ~(7'(regv[i][n] || n == 3 || n == 4) << (n - 1))});
        acc(16'hC000 + 16'(n * 272), 1'b0);
        chk("rom", {1'b0, rom}, {1'b0, ~(7'(regv[i][n] && n != 3) << (n - 1))});
      end
    end
    acc(16'hC0A5, 1'b0);
    chk("ioloc", {4'h0, iloc}, 8'h05);
    for (int x = 0; x < 2; x++) begin
      aux = x[0];
      acc(16'hC2FF, 1'b0);
      chk("romloc", rloc, 8'hFF);
      acc(16'hC800, 1'b0);
      chk("strobe", {drv, es, e3}, {2'b10, x[0]});
      d = 8'hC2;
      acc(16'h07F8, 1'b1);
      acc(16'hCFFF, 1'b0);
      chk("card", {7'h00, drv}, 8'h00);
    end
    v = 1'b0;
    @(posedge clk);
    #1;
    chk("idle", {rom, es}, 8'hFF);
    give_verdict();
  end
endmodule // tb_top
